// ### shared/ebc_pkg.sv
// constants and carriers for the byte store access control block
// assumes the cpu core decodes bank 0 direct and bank 1 indirect accesses
package ebc_pkg;
  // ************************************************************
  // map and layout
  // ************************************************************
  localparam logic [7:0] EBC_CTRL_OFFSET = 8'h40;
  localparam logic [7:0] EBC_CTRL_BANK = 8'h01;
  localparam int EBC_DEPTH = 64;
  localparam int EBC_AW = 6;
  localparam int EBC_BIT_WPERMIT = 3;
  localparam int EBC_BIT_WSTART = 2;
  localparam int EBC_BIT_RPERMIT = 1;
  localparam int EBC_BIT_RSTART = 0;
  localparam logic [3:0] EBC_CTRL_RESET = 4'h0;
  localparam logic [1:0] EBC_ADDR_PAD = 2'h0;
  localparam logic [3:0] EBC_CTRL_PAD = 4'h0;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int EBC_CLOCK_MHZ = 200;
  localparam int EBC_READ_CYCLES = 2;
  localparam logic [1:0] EBC_READ_LAST = 2'(EBC_READ_CYCLES - 1);
  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic addr_wr;
    logic data_wr;
    logic ctrl_wr;
    logic [7:0] wdata;
  } ebc_req_t;
  typedef enum logic [1:0] {
    EBC_IDLE = 2'h0,
    EBC_READ = 2'h1,
    EBC_WRITE = 2'h2
  } ebc_phase_t;
  typedef struct packed {
    ebc_phase_t phase;
    logic [EBC_AW-1:0] addr;
    logic [EBC_AW-1:0] cyc_addr;
    logic [7:0] data;
    logic wpermit;
    logic wstart;
    logic rpermit;
    logic rstart;
    logic [1:0] rcount;
    logic done_flag;
    logic wr_go;
    logic [2:0] done_sync;
  } ebc_state_t;
endpackage : ebc_pkg

// ### src/ebc_access.sv
// access control for the 64-byte non-volatile byte store
// assumes the cpu core presents decoded register strobes, one per cycle
// and the write timer answers with an asynchronous done level
module ebc_access (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register strobes from the core
  input wire ebc_pkg::ebc_req_t req,
  input wire logic done_flag_clr,
  // register read values
  output logic [7:0] addr_rdata,
  output logic [7:0] data_rdata,
  output logic [7:0] ctrl_rdata,
  // asynchronous write timer
  output logic timer_start,
  input wire logic timer_done,
  // write completion events
  output logic store_write_done_flag,
  output logic write_done_pulse
);
  import ebc_pkg::*;
  // ************************************************************
  // state
  // ************************************************************
  ebc_state_t st;
  ebc_state_t next_st;
  logic [7:0] mem [EBC_DEPTH];
  logic rd_fire;
  logic wr_fire;
  logic wr_end;
  logic rd_end;
  // bit zero of the sync chain feeds only bit one, nothing else
  // edge detect, so a done level left from the last write ends nothing
  assign wr_end = (st.phase == EBC_WRITE) && st.wr_go &&
                  st.done_sync[1] && !st.done_sync[2];
  assign rd_end = (st.phase == EBC_READ) && (st.rcount == EBC_READ_LAST);
  assign rd_fire = rd_end && st.rpermit;
  assign wr_fire = (st.phase == EBC_WRITE) && !st.wr_go &&
                   !st.done_sync[1] && st.wpermit;
  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_st = st;
    next_st.done_sync = {st.done_sync[1:0], timer_done};
    if (req.addr_wr) begin
      next_st.addr = req.wdata[EBC_AW-1:0];
    end
    if (req.data_wr) begin
      next_st.data = req.wdata;
    end
    if (req.ctrl_wr) begin
      next_st.wpermit = req.wdata[EBC_BIT_WPERMIT];
      next_st.rpermit = req.wdata[EBC_BIT_RPERMIT];
      // a start needs its permit already set before this write
      if (st.phase == EBC_IDLE) begin
        if (req.wdata[EBC_BIT_WSTART] && st.wpermit) begin
          next_st.wstart = 1'b1;
          next_st.phase = EBC_WRITE;
          next_st.cyc_addr = st.addr;
          next_st.wr_go = 1'b0;
        end else if (req.wdata[EBC_BIT_RSTART] && st.rpermit) begin
          next_st.rstart = 1'b1;
          next_st.phase = EBC_READ;
          next_st.cyc_addr = st.addr;
          next_st.rcount = 2'h0;
        end
      end
    end
    // a cycle in flight ignores starts; the latched address drives it
    unique case (st.phase)
      EBC_IDLE: begin
      end
      EBC_READ: begin
        next_st.rcount = 2'(st.rcount + 2'h1);
        if (rd_end) begin
          next_st.phase = EBC_IDLE;
          next_st.rstart = 1'b0;
          if (rd_fire) begin
            next_st.data = mem[st.cyc_addr];
          end
        end
      end
      EBC_WRITE: begin
        // wait for the old done level to drop before launching
        if (wr_fire) begin
          next_st.wr_go = 1'b1;
        end else if (!st.wr_go && !st.wpermit) begin
          next_st.phase = EBC_IDLE;
          next_st.wstart = 1'b0;
        end
        if (wr_end) begin
          next_st.phase = EBC_IDLE;
          next_st.wstart = 1'b0;
          next_st.wr_go = 1'b0;
        end
      end
      default: begin
        next_st.phase = EBC_IDLE;
      end
    endcase
    // set wins over a clear in the same cycle
    if (done_flag_clr) begin
      next_st.done_flag = 1'b0;
    end
    if (wr_end) begin
      next_st.done_flag = 1'b1;
    end
  end
  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // addr and data clear too, software still treats them as unknown
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  // byte array stays out of reset: contents survive like the real cells
  always_ff @(posedge clock) begin
    if (wr_fire) begin
      mem[st.cyc_addr] <= st.data;
    end
  end
  // ************************************************************
  // outputs
  // ************************************************************
  assign addr_rdata = {EBC_ADDR_PAD, st.addr};
  assign data_rdata = st.data;
  assign ctrl_rdata = {EBC_CTRL_PAD, st.wpermit, st.wstart,
                       st.rpermit, st.rstart};
  // registered so the asynchronous timer never sees a glitch
  assign timer_start = st.wr_go;
  assign store_write_done_flag = st.done_flag;
  assign write_done_pulse = wr_end;
  // ************************************************************
  // checks
  // ************************************************************
  sequence rd_launch_s;
    req.ctrl_wr && req.wdata[EBC_BIT_RSTART] && st.rpermit &&
    st.phase == EBC_IDLE && !(req.wdata[EBC_BIT_WSTART] && st.wpermit);
  endsequence
  sequence rd_busy_s;
    st.rstart [*2];
  endsequence
  rd_cycle_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd_launch_s |=> rd_busy_s ##1 !st.rstart)
    else $error("read start did not clear after two cycles");
  rd_block_a: assert property (@(posedge clock) disable iff (!rst_n)
    (req.ctrl_wr && !st.rpermit && st.phase == EBC_IDLE &&
     !req.wdata[EBC_BIT_WSTART]) |=> !st.rstart)
    else $error("read started without permit");
  wr_block_a: assert property (@(posedge clock) disable iff (!rst_n)
    (req.ctrl_wr && !st.wpermit && st.phase == EBC_IDLE) |=> !st.wstart)
    else $error("write started without permit");
  wr_launch_a: assert property (@(posedge clock) disable iff (!rst_n)
    (req.ctrl_wr && req.wdata[EBC_BIT_WSTART] && st.wpermit &&
     st.phase == EBC_IDLE) |=> st.wstart)
    else $error("write start not taken");
  wr_permit_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(timer_start) |-> $past(st.wpermit))
    else $error("write launched without permit");
  // an abort is only possible before the timer has been launched
  wr_abort_a: assert property (@(posedge clock) disable iff (!rst_n)
    (st.phase == EBC_WRITE && !st.wr_go && !st.wpermit)
      |=> !st.wstart && !timer_start)
    else $error("write went on after permit was cleared");
  // the timer must see a steady start level or the cell write is cut short
  timer_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (timer_start && !wr_end) |=> timer_start)
    else $error("timer start dropped before the write ended");
  pulse_once_a: assert property (@(posedge clock) disable iff (!rst_n)
    write_done_pulse |=> !write_done_pulse)
    else $error("write done pulse longer than one cycle");
  start_excl_a: assert property (@(posedge clock) disable iff (!rst_n)
    !(st.wstart && st.rstart))
    else $error("read and write cycles running together");
  rd_refuse_a: assert property (@(posedge clock) disable iff (!rst_n)
    (rd_end && !st.rpermit && !req.data_wr) |=> $stable(st.data))
    else $error("read without permit changed the data register");
  wr_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr_end |=> !st.wstart && st.done_flag)
    else $error("write start not cleared at timer end");
  done_sticky_a: assert property (@(posedge clock) disable iff (!rst_n)
    (st.done_flag && !done_flag_clr) |=> st.done_flag)
    else $error("done flag dropped without clear");
  busy_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (st.phase != EBC_IDLE && next_st.phase != EBC_IDLE)
      |=> $stable(st.cyc_addr))
    else $error("cycle address changed while busy");
  rd_data_a: assert property (@(posedge clock) disable iff (!rst_n)
    (st.phase == EBC_IDLE && !req.data_wr) |=> $stable(st.data))
    else $error("data changed with no operation");
  pad_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl_rdata[7:4] == EBC_CTRL_PAD && addr_rdata[7:6] == EBC_ADDR_PAD)
    else $error("unimplemented bits not zero");
endmodule : ebc_access

// ### tb/tb_top.sv
// self-checking bench for the byte store access control block
// assumes the core strobes registers one at a time and a slow write timer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ebc_pkg::*;
  logic clock, rst_n, done_flag_clr, timer_start, prev_rd;
  logic timer_done = 1'b0;
  ebc_req_t req;
  logic [7:0] addr_rdata, data_rdata, ctrl_rdata, ex;
  logic store_write_done_flag, write_done_pulse;
  logic [7:0] exp_q[$];
  int err_count, n_tests, tcnt, n_pulse;
  logic [5:0] a;
  logic [7:0] d;

  ebc_access DUT (.clock(clock), .rst_n(rst_n), .req(req),
    .done_flag_clr(done_flag_clr), .addr_rdata(addr_rdata),
    .data_rdata(data_rdata), .ctrl_rdata(ctrl_rdata),
    .timer_start(timer_start), .timer_done(timer_done),
    .store_write_done_flag(store_write_done_flag),
    .write_done_pulse(write_done_pulse));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // ************************************************************
  // write timer stand-in: done falls only after start drops
  // ************************************************************
  always @(negedge clock) begin
    if (timer_start !== 1'b1) begin
      timer_done <= 1'b0;
      tcnt <= 0;
    end else if (tcnt == 6) timer_done <= 1'b1;
    else tcnt <= tcnt + 1;
  end
  // ************************************************************
  // monitor: a falling read start releases the oldest note
  // ************************************************************
  always @(negedge clock) begin
    if (prev_rd === 1'b1 && ctrl_rdata[0] === 1'b0) begin
      ex = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
      n_tests++;
      if (data_rdata !== ex) begin
        err_count++;
        $display("Error %0t: read byte %h expected %h", $time, data_rdata, ex);
      end
    end
    if (write_done_pulse === 1'b1) n_pulse++;
    prev_rd = ctrl_rdata[0];
  end
  // ************************************************************
  // tasks
  // ************************************************************
  task put(input int k, input logic [7:0] v);
    @(negedge clock);
    req.wdata = v;
    req.addr_wr = (k == 0);
    req.data_wr = (k == 1);
    req.ctrl_wr = (k == 2);
    @(negedge clock);
    req = '0;
  endtask : put
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wait_low(input int b);
    int i;
    for (i = 0; i < 60 && ctrl_rdata[b] !== 1'b0; i++) @(negedge clock);
  endtask : wait_low
  task store(input logic [5:0] sa, input logic [7:0] sd);
    put(0, {2'h0, sa});
    put(1, sd);
    n_pulse = 0;
    put(2, 8'h08);
    put(2, 8'h0c);
    chk(ctrl_rdata, 8'h0c);
    @(negedge clock);
    chk({7'h0, timer_start}, 8'h01);
    wait_low(EBC_BIT_WSTART);
    chk(ctrl_rdata, 8'h08);
    chk({7'h0, timer_start}, 8'h00);
    chk(8'(n_pulse), 8'h01);
    chk({7'h0, store_write_done_flag}, 8'h01);
    @(negedge clock) done_flag_clr = 1'b1;
    @(negedge clock) done_flag_clr = 1'b0;
    @(negedge clock);
    chk({7'h0, store_write_done_flag}, 8'h00);
  endtask : store
  task fetch(input logic [5:0] fa, input logic [7:0] fd);
    put(0, {2'h0, fa});
    put(1, ~fd);
    put(2, 8'h02);
    exp_q.push_back(fd);
    put(2, 8'h03);
    wait_low(EBC_BIT_RSTART);
    repeat (5) @(negedge clock);
    chk(data_rdata, fd);
  endtask : fetch
  task summarize;
    if (exp_q.size() != 0) begin
      err_count++;
      $display("Error %0t: %0d read notes unanswered", $time, exp_q.size());
    end
    $display("errors %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rst_n = 1'b0;
    req = '0;
    done_flag_clr = 1'b0;
    prev_rd = 1'b0;
    err_count = 0;
    n_tests = 0;
    void'($urandom(32'h4973));
    repeat (10) @(posedge clock);
    @(negedge clock) rst_n = 1'b1;
    chk(ctrl_rdata, {EBC_CTRL_PAD, EBC_CTRL_RESET});
    put(0, 8'hff);
    chk(addr_rdata, 8'h3f);
    put(2, 8'h04);
    @(negedge clock);
    chk({ctrl_rdata[6:0], timer_start}, 8'h00);
    put(2, 8'h01);
    chk(ctrl_rdata, 8'h00);
    put(2, 8'hf0);
    chk(ctrl_rdata, 8'h00);
    put(1, 8'ha5);
    chk(data_rdata, 8'ha5);
    for (int k = 0; k < 6; k++) begin
      a = (k == 0) ? 6'h00 : (k == 1) ? 6'h3f : 6'($urandom);
      d = 8'($urandom);
      store(a, d);
      fetch(a, d);
    end
    // mid-run reset: control clears, the cells keep their bytes
    @(negedge clock) rst_n = 1'b0;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    chk(ctrl_rdata, {EBC_CTRL_PAD, EBC_CTRL_RESET});
    put(0, {2'h0, a});
    put(1, ~d);
    put(2, 8'h02);
    exp_q.push_back(d);
    put(2, 8'h03);
    put(2, 8'h03);
    chk(ctrl_rdata, 8'h02);
    wait_low(EBC_BIT_RSTART);
    chk(data_rdata, d);
    put(2, 8'h00);
    put(2, 8'h01);
    chk(ctrl_rdata, 8'h00);
    summarize;
  end
  initial begin
    #(20000 * 5);
    err_count++;
    summarize;
  end
endmodule : tb_top
